/* logic/adcc_cfg.svh */
/*
 * Constants of the converter control block: register indices, field
 * positions, reset values and conversion timing counts.
 * Assumes it is included by bare name from logic that uses them.
 */
`ifndef ADCC_CFG_SVH
`define ADCC_CFG_SVH

// register indices; byte address is four times the index
`define ADCC_IDX_RESULT     12'h01E
`define ADCC_IDX_CTRL       12'h01F
`define ADCC_IDX_IRQ        12'h020
`define ADCC_IDX_PINCFG     12'h09F

// conversion control fields
`define ADCC_CTRL_ON_BIT    0
`define ADCC_CTRL_GO_BIT    2
`define ADCC_CTRL_CHS_LSB   3
`define ADCC_CTRL_CLK_LSB   6
`define ADCC_CTRL_RESET     8'h00
`define ADCC_PINCFG_RESET   3'h0

// interrupt register fields
`define ADCC_IRQ_FLAG_BIT   0
`define ADCC_IRQ_EN_BIT     1

// half of one bit period less one, in oscillator cycles, per clock select
`define ADCC_HALF_DIV2      4'h0
`define ADCC_HALF_DIV8      4'h3
`define ADCC_HALF_DIV32     4'hF

// 9.5 bit periods are 19 half periods, counted 0 to 18
`define ADCC_HALF_LAST      5'h12
`define ADCC_HALF_TRIAL_END 5'h0F

`endif

/* logic/adcc_ctrl.sv */
/*
 * Converter control block: APB register file, conversion sequencer with
 * successive approximation, go/done handshake, result and completion flag.
 * Assumes an APB master on mclk_i, a comparator answer that settles within
 * the cycle on mclk_i, a special event trigger pulse from logic on mclk_i, and an
 * internal RC clock that is asynchronous.
 */
//Function
//[RULE1] clock select picks osc/2, /8, /32 or RC
//[RULE2] channel field bits 5..3 routes channels 0..4
//[RULE3] writing go while on starts conversion
//[RULE4] hardware clears go when conversion finishes
//[RULE5] on bit powers converter; off draws nothing
//[RULE6] unused bits ignore writes, read zero
//[RULE7] pin config field sets analog/digital/reference roles
//[RULE8] completion loads result, clears go, sets flag
//[RULE9] result register kept across reset
//[RULE10] software waits acquisition before setting go
//[RULE11] software sets analog pins as inputs
//[RULE12] software follows configure, wait, start, poll sequence
//[RULE13] software waits two bit periods between conversions
//[RULE14] control bits reset to zero
//[RULE15] any reset aborts conversion, turns converter off
//[RULE16] conversion lasts nine and a half bit periods
//[RULE17] special trigger starts conversion only when on
//[RULE18] software avoids go in the power-on write
//[RULE19] turning off mid-conversion abandons it quietly
//[RULE20] interrupt while flag and enable both set
`timescale 1ns/1ps
`include "adcc_cfg.svh"

module adcc_ctrl #(
    parameter int DATA_W = 8
) (
    input  wire logic                 mclk_i,
    input  wire logic                 rst_n_i,
    input  wire logic                 psel_i,
    input  wire logic                 penable_i,
    input  wire logic                 pwrite_i,
    input  wire logic [11:0]          paddr_i,
    input  wire logic [31:0]          pwdata_i,
    output logic      [31:0]          prdata_o,
    output logic                      pready_o,
    output logic                      pslverr_o,
    input  wire logic                 cmp_above_i,
    input  wire logic                 rc_clk_i,
    input  wire logic                 special_trigger_i,
    output adcc_pkg::adcc_analog_t    analog_o,
    output logic                      irq_o
);
    import adcc_pkg::*;

    initial begin
        if (DATA_W != 8) begin
            $error("adcc_ctrl serves an 8-bit result only");
        end
    end

    // register index match for an aligned word address
    function automatic logic hit(input logic [11:0] addr, input logic [11:0] idx);
        hit = (addr[1:0] == 2'b00) && (addr[11:2] == idx[9:0]);
    endfunction

    adcc_state_t       state;
    logic [1:0]        clk_sel;
    logic [2:0]        chan_sel;
    logic              go_busy;
    logic              conv_on;
    logic [2:0]        pin_cfg;
    logic [DATA_W-1:0] result;
    logic              flag;
    logic              irq_en;
    logic [4:0]        half_cnt;
    logic [DATA_W-1:0] trial;
    logic [DATA_W-1:0] probe;
    logic              half_tick;

    // bus decode
    logic        setup;
    logic        wr_access;
    logic        sel_ctrl;
    logic        sel_pin;
    logic        sel_res;
    logic        sel_irq;
    logic        mapped;
    logic        wr_ctrl;
    logic        wr_pin;
    logic        wr_irq;
    logic [31:0] read_word;

    assign setup     = psel_i && !penable_i;
    assign wr_access = psel_i && penable_i && pready_o && pwrite_i;
    assign sel_ctrl  = hit(paddr_i, `ADCC_IDX_CTRL);
    assign sel_pin   = hit(paddr_i, `ADCC_IDX_PINCFG);
    assign sel_res   = hit(paddr_i, `ADCC_IDX_RESULT);
    assign sel_irq   = hit(paddr_i, `ADCC_IDX_IRQ);
    assign mapped    = sel_ctrl || sel_pin || sel_res || sel_irq;
    assign wr_ctrl   = wr_access && sel_ctrl;
    assign wr_pin    = wr_access && sel_pin;
    assign wr_irq    = wr_access && sel_irq;

    // readback; bit 1 of control and bits 7..3 of pin config read zero
    logic [7:0] ctrl_word;
    assign ctrl_word = {clk_sel, chan_sel, go_busy, 1'b0, conv_on}; // [RULE6]
    assign read_word = sel_ctrl ? {24'h000000, ctrl_word} :
                       sel_pin  ? {29'h00000000, pin_cfg} : // [RULE6]
                       sel_res  ? {24'h000000, result} :
                       sel_irq  ? {30'h00000000, irq_en, flag} : 32'h00000000;

    // start and completion conditions
    logic new_on;
    logic sw_start;
    logic trig_start;
    logic start;
    logic finish;
    logic abort;
    logic trial_step;

    assign new_on     = wr_ctrl ? pwdata_i[`ADCC_CTRL_ON_BIT] : conv_on;
    // go only counts when the converter was already on before this write
    assign sw_start   = wr_ctrl && pwdata_i[`ADCC_CTRL_GO_BIT] && conv_on; // [RULE3]
    assign trig_start = special_trigger_i && conv_on; // [RULE17]
    assign start      = (state == ADCC_IDLE) && (sw_start || trig_start) && new_on;
    assign abort      = (state == ADCC_CONV) && !new_on; // [RULE19]
    assign finish     = (state == ADCC_CONV) && half_tick && !abort
                        && (half_cnt == `ADCC_HALF_LAST); // [RULE16]
    assign trial_step = (state == ADCC_CONV) && half_tick && half_cnt[0]
                        && (half_cnt <= `ADCC_HALF_TRIAL_END);

    // per-bit clock for the sequencer
    adcc_tad_gen u_tad (
        .mclk_i      (mclk_i),
        .rst_n_i     (rst_n_i),
        .run_i       (state == ADCC_CONV),
        .sel_i       (clk_sel),
        .rc_clk_i    (rc_clk_i),
        .half_tick_o (half_tick)
    );

    // comparator follows the held trial code on this clock; a two-flop
    // crossing would make each decision see a stale trial at osc/2, where
    // a bit period is only two cycles long

    // APB answer: registered, zero wait states, error on unmapped word
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h00000000;
        end else begin
            pready_o  <= setup;
            pslverr_o <= setup && !mapped;
            prdata_o  <= (setup && !pwrite_i) ? read_word : 32'h00000000;
        end
    end

    // software-owned control fields
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            clk_sel  <= 2'b00; // [RULE14] [RULE15]
            chan_sel <= 3'b000;
            conv_on  <= 1'b0;
            pin_cfg  <= `ADCC_PINCFG_RESET;
            irq_en   <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                clk_sel  <= pwdata_i[`ADCC_CTRL_CLK_LSB +: 2];
                chan_sel <= pwdata_i[`ADCC_CTRL_CHS_LSB +: 3]; // [RULE2]
                conv_on  <= pwdata_i[`ADCC_CTRL_ON_BIT]; // [RULE5]
            end
            if (wr_pin) begin
                pin_cfg <= pwdata_i[2:0]; // [RULE6]
            end
            if (wr_irq) begin
                irq_en <= pwdata_i[`ADCC_IRQ_EN_BIT];
            end
        end
    end

    // sequencer state and go/done; software writing go as 0 is ignored
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            state    <= ADCC_IDLE; // [RULE15]
            go_busy  <= 1'b0;
            half_cnt <= 5'h00;
        end else if (start) begin
            state    <= ADCC_CONV;
            go_busy  <= 1'b1; // [RULE3] [RULE17]
            half_cnt <= 5'h00;
        end else if (finish || abort) begin
            state    <= ADCC_IDLE;
            go_busy  <= 1'b0; // [RULE4] [RULE19]
            half_cnt <= 5'h00;
        end else if (state == ADCC_CONV && half_tick) begin
            half_cnt <= half_cnt + 5'h01;
        end
    end

    // successive approximation: one bit decided every bit period
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i || start) begin
            trial <= {1'b1, {(DATA_W-1){1'b0}}};
            probe <= {1'b1, {(DATA_W-1){1'b0}}};
        end else if (trial_step) begin
            trial <= (cmp_above_i ? trial : (trial & ~probe)) | (probe >> 1);
            probe <= probe >> 1;
        end
    end

    // result is left alone by reset so it survives until the next finish
    always_ff @(posedge mclk_i) begin
        if (finish) begin
            result <= trial; // [RULE8] [RULE9]
        end
    end

    // completion flag: a finish in the clearing cycle wins over the clear
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            flag <= 1'b0;
        end else if (finish) begin
            flag <= 1'b1; // [RULE8]
        end else if (wr_irq && !pwdata_i[`ADCC_IRQ_FLAG_BIT]) begin
            flag <= 1'b0; // [RULE20]
        end
    end

    // pin role decode from the configuration field
    logic [4:0] analog_pins;
    logic       vref_ext;
    assign analog_pins = pin_cfg[2:1] == 2'b11 ? 5'b00000 :
                         pin_cfg[2]   ? 5'b11001 : 5'b11111; // [RULE7]
    assign vref_ext    = pin_cfg[0] && (pin_cfg[2:1] != 2'b11); // [RULE7]

    // analog side and interrupt, all from flops
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            analog_o <= '0;
            irq_o    <= 1'b0;
        end else begin
            analog_o.powered       <= conv_on; // [RULE5]
            analog_o.hold          <= (state == ADCC_CONV);
            analog_o.channel       <= chan_sel; // [RULE2]
            analog_o.analog_pins   <= analog_pins;
            analog_o.vref_external <= vref_ext;
            analog_o.trial_code    <= trial;
            irq_o                  <= flag && irq_en; // [RULE20]
        end
    end
endmodule

/* logic/adcc_pkg.sv */
/*
 * Types of the converter control block.
 * Assumes adcc_cfg.svh carries the numeric constants.
 */
package adcc_pkg;

    typedef enum logic {
        ADCC_IDLE,
        ADCC_CONV
    } adcc_state_t;

    // drive toward the analog multiplexer, sample-hold and comparator
    typedef struct packed {
        logic       powered;
        logic       hold;
        logic [2:0] channel;
        logic [4:0] analog_pins;
        logic       vref_external;
        logic [7:0] trial_code;
    } adcc_analog_t;

endpackage

/* logic/adcc_tad_gen.sv */
/*
 * Half-bit-period tick generator: divides the oscillator or follows the
 * internal RC clock, depending on the clock select.
 * Assumes mclk_i is the oscillator and rc_clk_i is asynchronous to it.
 */
`timescale 1ns/1ps
`include "adcc_cfg.svh"

module adcc_tad_gen (
    input  wire logic       mclk_i,
    input  wire logic       rst_n_i,
    input  wire logic       run_i,
    input  wire logic [1:0] sel_i,
    input  wire logic       rc_clk_i,
    output logic            half_tick_o
);
    logic [3:0] cnt;
    logic [3:0] reload;
    logic       rc_meta;
    logic       rc_sync;
    logic       rc_last;
    logic       rc_edge;
    logic       div_tick;

    // each half period of the conversion clock, in oscillator cycles less one
    assign reload   = (sel_i == 2'b00) ? `ADCC_HALF_DIV2 :
                      (sel_i == 2'b01) ? `ADCC_HALF_DIV8 : `ADCC_HALF_DIV32;
    assign div_tick = (cnt == 4'h0);
    assign rc_edge  = rc_sync ^ rc_last;

    // rc clock crosses in two flops; edges are seen on the second only
    always_ff @(posedge mclk_i) begin
        rc_meta <= rc_clk_i;
        rc_sync <= rc_meta;
        rc_last <= rc_sync;
    end

    // divider reloads while idle, so the first half period is a full one
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            cnt         <= 4'h0;
            half_tick_o <= 1'b0;
        end else if (!run_i) begin
            cnt         <= reload;
            half_tick_o <= 1'b0;
        end else begin
            cnt         <= div_tick ? reload : cnt - 4'h1;
            half_tick_o <= (sel_i == 2'b11) ? rc_edge : div_tick; // [RULE1]
        end
    end
endmodule

/* verification/adcc_analog_model.sv */
/*
 * Far-side model: comparator of the held channel against a target level.
 * Assumes trial code, hold and power come from adcc_ctrl on mclk_i.
 */
`timescale 1ns/1ps
module adcc_analog_model (
    input  wire logic                   mclk_i,
    input  wire adcc_pkg::adcc_analog_t analog_i,
    input  wire logic [7:0]             level_i,
    output logic                        cmp_above_o
);
    import adcc_pkg::*;
    logic toggle = 1'b0;
    // level_i stands for a pin whose direction is set as input
    // an idle comparator gives noise, so a stale answer cannot pass for a real one
    always @(posedge mclk_i) begin
        toggle <= ~toggle;
    end
    assign cmp_above_o = (analog_i.powered && analog_i.hold) ?
                         (level_i >= analog_i.trial_code) : toggle;
endmodule

/* verification/adcc_ctrl_assertions.sv */
/*
 * Port checker of the converter control block.
 * Assumes it is bound to adcc_ctrl and sees only its ports.
 */
`timescale 1ns/1ps
module adcc_ctrl_checker (
    input wire logic                   mclk_i,
    input wire logic                   rst_n_i,
    input wire logic                   psel_i,
    input wire logic                   penable_i,
    input wire logic                   pwrite_i,
    input wire logic [11:0]            paddr_i,
    input wire logic [31:0]            pwdata_i,
    input wire logic [31:0]            prdata_o,
    input wire logic                   pready_o,
    input wire logic                   pslverr_o,
    input wire adcc_pkg::adcc_analog_t analog_o,
    input wire logic                   irq_o
);
    import adcc_pkg::*;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    // bus answer timing and refusals
    chk_ready_next: assert property (psel_i && !penable_i |=> pready_o)
        else $error("no ready after setup");
    chk_ready_once: assert property (pready_o |=> !pready_o)
        else $error("ready held too long");
    chk_bad_addr: assert property (pready_o && !(paddr_i inside
        {12'h078, 12'h07C, 12'h080, 12'h27C}) |-> pslverr_o && prdata_o == 32'h0)
        else $error("unmapped access not refused");
    chk_pin_zero: assert property (pready_o && !pwrite_i && paddr_i == 12'h27C
        |-> prdata_o[31:3] == 29'h0) else $error("pin config upper bits set");
    chk_ctrl_bit1: assert property (pready_o && !pwrite_i && paddr_i == 12'h07C
        |-> !prdata_o[1] && prdata_o[31:8] == 24'h0) else $error("control unused bit set");
    // converter power, conversion length, reset state and interrupt disable
    chk_off_idle: assert property (!analog_o.powered ##1 !analog_o.powered
        |-> !analog_o.hold) else $error("conversion while off");
    chk_hold_min: assert property ($rose(analog_o.hold) |=> analog_o.hold[*8])
        else $error("conversion too short");
    chk_rst_clear: assert property ($rose(rst_n_i) |-> !analog_o.powered
        && !analog_o.hold && !irq_o) else $error("reset left converter active");
    chk_irq_off: assert property (pready_o && pwrite_i && paddr_i == 12'h080
        && !pwdata_i[1] |-> ##[1:3] !irq_o) else $error("irq stays when disabled");
endmodule
bind adcc_ctrl adcc_ctrl_checker u_chk (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .analog_o(analog_o), .irq_o(irq_o));

/* verification/adcc_ctrl_bench.sv */
/*
 * Self-checking bench of the converter control block.
 * Assumes the analog model and the checker are compiled before it.
 */
`timescale 1ns/1ps
module adcc_ctrl_bench;
    import adcc_pkg::*;
    localparam logic [11:0] A_RES = 12'h078;
    localparam logic [11:0] A_CTRL = 12'h07C;
    localparam logic [11:0] A_IRQ = 12'h080;
    localparam logic [11:0] A_PIN = 12'h27C;
    logic         mclk_i = 1'b0;
    logic         rst_n_i = 1'b0;
    logic         psel = 1'b0;
    logic         pen = 1'b0;
    logic         pwr = 1'b0;
    logic         trig = 1'b0;
    logic         rc_clk = 1'b0;
    logic [11:0]  paddr = 12'h000;
    logic [31:0]  pwdata = 32'h0;
    logic [31:0]  prdata;
    logic         pready, pslverr, cmp, irq;
    logic [7:0]   level = 8'h00;
    logic [7:0]   last;
    adcc_analog_t ana;
    logic [32:0]  expq[$];
    int           miscompares = 0;
    int           check_count = 0;
    int           n;
    // rc clock unrelated in phase to the oscillator
    always #2 mclk_i = ~mclk_i;
    always #7.3 rc_clk = ~rc_clk;
    adcc_ctrl u_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(pen),
        .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .cmp_above_i(cmp), .rc_clk_i(rc_clk),
        .special_trigger_i(trig), .analog_o(ana), .irq_o(irq));
    adcc_analog_model u_ana (.mclk_i(mclk_i), .analog_i(ana), .level_i(level),
        .cmp_above_o(cmp));
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // one apb transfer; a read leaves its expected {pslverr, prdata} in the queue
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [32:0] e);
        int k;
        k = 0;
        @(posedge mclk_i);
        psel   <= 1'b1;
        pwr    <= w;
        paddr  <= a;
        pwdata <= d;
        if (!w) expq.push_back(e);
        @(posedge mclk_i);
        pen <= 1'b1;
        do begin
            @(posedge mclk_i);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) begin
            miscompares++;
            close_out();
        end
        psel <= 1'b0;
        pen  <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 33'h0);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0, {1'b0, e});
    endtask
    // bounded wait for the converter to let go of the hold
    task automatic wait_done();
        n = 0;
        while (ana.hold === 1'b1 && n < 3000) begin
            @(posedge mclk_i);
            n++;
        end
        if (n >= 3000) begin
            miscompares++;
            close_out();
        end
    endtask
    task automatic conv(input logic [1:0] s, input logic [2:0] c);
        int d;
        d = (s == 2'h0) ? 19 : (s == 2'h1) ? 76 : 304;
        level = 8'($urandom);
        wr(A_CTRL, {24'h0, s, c, 3'b001}); // power on before go
        repeat (10) @(posedge mclk_i); // acquisition
        wr(A_CTRL, {24'h0, s, c, 3'b101});
        rd(A_CTRL, {24'h0, s, c, 3'b101});
        chk({30'h0, ana.channel}, {30'h0, c});
        wait_done();
        if (s != 2'h3) chk({32'h0, (n >= d - 1 && n <= d + 3)}, 33'h1);
        rd(A_RES, {24'h0, level});
        rd(A_CTRL, {24'h0, s, c, 3'b001});
        rd(A_IRQ, 32'h3);
        chk({32'h0, irq}, 33'h1);
        wr(A_IRQ, 32'h2);
        last = level;
        repeat (70) @(posedge mclk_i); // gap of two bit periods
    endtask
    // monitor: each read answer takes the oldest note off the queue
    always @(posedge mclk_i) begin
        if (psel && pen && pready === 1'b1 && !pwr) begin
            if (expq.size() == 0) miscompares++;
            else chk({pslverr, prdata}, expq.pop_front());
        end
    end
    initial begin
        void'($urandom(32'hAC06));
        repeat (3) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        rd(A_CTRL, 32'h0);
        rd(A_PIN, 32'h0);
        wr(A_PIN, 32'hFF);
        rd(A_PIN, 32'h7);
        bus(1'b0, 12'h004, 32'h0, {1'b1, 32'h0});
        for (int i = 0; i < 8; i++) begin
            wr(A_PIN, 32'(i));
            repeat (2) @(posedge mclk_i);
            chk({28'h0, ana.analog_pins[4:1], ana.vref_external}, {28'h0,
                i[2] ? (i[1] ? 4'h0 : 4'hC) : 4'hF, i[0] & ~(i[2] & i[1])});
        end
        wr(A_IRQ, 32'h2);
        for (int i = 0; i < 5; i++) conv(2'(i), 3'(i));
        // switch off in mid conversion
        wr(A_CTRL, 32'h85);
        repeat (100) @(posedge mclk_i);
        wr(A_CTRL, 32'h80);
        rd(A_CTRL, 32'h80);
        rd(A_RES, {24'h0, last});
        rd(A_IRQ, 32'h2);
        chk({32'h0, ana.powered}, 33'h0);
        // special trigger, first while off, then while on
        for (int i = 0; i < 2; i++) begin
            if (i == 1) wr(A_CTRL, 32'h01);
            repeat (10) @(posedge mclk_i);
            trig <= 1'b1;
            @(posedge mclk_i);
            trig <= 1'b0;
            repeat (3) @(posedge mclk_i);
            chk({32'h0, ana.hold}, 33'(i));
        end
        wait_done();
        rd(A_IRQ, 32'h3);
        // reset in mid conversion
        wr(A_CTRL, 32'h85);
        repeat (50) @(posedge mclk_i);
        rst_n_i <= 1'b0;
        repeat (3) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        rd(A_CTRL, 32'h0);
        rd(A_PIN, 32'h0);
        rd(A_RES, {24'h0, last});
        wr(A_IRQ, 32'h0);
        rd(A_IRQ, 32'h0);
        repeat (3) @(posedge mclk_i);
        close_out();
    end
endmodule
